//--- pkg/lie_pkg.sv
// Package for the link interrupt event register block
package lie_pkg;

  localparam logic [7:0] LIE_OFF_EVENT_SET   = 8'h80;
  localparam logic [7:0] LIE_OFF_EVENT_CLEAR = 8'h84;
  localparam logic [7:0] LIE_OFF_MASK        = 8'h88;
  localparam logic [7:0] LIE_OFF_CONTROL     = 8'h8C;
  localparam logic [7:0] LIE_OFF_PHY_DATA    = 8'h90;

  localparam int LIE_BIT_SOFT      = 29;
  localparam int LIE_BIT_TARDY     = 27;
  localparam int LIE_BIT_PHY_REG   = 26;
  localparam int LIE_BIT_OVERRUN   = 25;
  localparam int LIE_BIT_FATAL     = 24;
  localparam int LIE_BIT_MISMATCH  = 23;
  localparam int LIE_BIT_LOST      = 22;
  localparam int LIE_BIT_SIXTYFOUR = 21;
  localparam int LIE_BIT_NEW_CYCLE = 20;
  localparam int LIE_BIT_PHY_INT   = 19;
  localparam int LIE_BIT_ACCESS    = 18;
  localparam int LIE_BIT_LOW       = 18;
  localparam int LIE_NUM_EVENTS    = 14;

  // Bits that exist; 31, 30 and 28 read zero
  localparam logic [31:0] LIE_EVENT_MASK   = 32'h2FFC_0000;
  localparam logic [31:0] LIE_RESET_EVENTS = 32'h0000_0000;
  localparam logic [31:0] LIE_RESET_MASK   = 32'h0000_0000;

  localparam int CTL_BIT_TARDY_EN  = 0;
  localparam int CTL_BIT_CYC_MSTR  = 1;
  localparam logic [1:0] LIE_RESET_CONTROL = 2'h0;

  localparam int LIE_SECONDS_HI = 6;
  localparam int LIE_PHY_LSB    = 16;

  localparam real LIE_CYCLE_LIMIT_US = 125.0;
  localparam real LIE_CLK_MHZ        = 200.0;
  localparam int  LIE_CYCLE_LIMIT_CYC = int'(LIE_CYCLE_LIMIT_US * LIE_CLK_MHZ);

  localparam logic [1:0] LIE_RESP_OKAY   = 2'h0;
  localparam logic [1:0] LIE_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       cycle_start_sent;
    logic       cycle_start_rcvd;
    logic       subaction_gap;
    logic       arb_reset_gap;
    logic [6:0] rx_seconds;
    logic [12:0] rx_count;
  } lie_cycle_s;

  typedef struct packed {
    logic rx_fifo_host_data;
    logic phys_resp_busy;
    logic tardy_ack_sent;
    logic phy_status_int;
    logic phy_reg_valid;
    logic [7:0] phy_reg_byte;
    logic link_clock_missing;
    logic access_attempt;
    logic fatal_error;
  } lie_src_s;

endpackage

//--- rtl/lie_axil_slave.sv
// AXI4-Lite slave front end: single write and read, one outstanding each
`timescale 1ns/1ps
module lie_axil_slave (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             wr_pulse,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);
  logic aw_held;
  logic w_held;
  wire  aw_take = awvalid && awready;
  wire  w_take  = wvalid && wready;
  wire  ar_take = arvalid && arready;
  wire  next_fire = (aw_held || aw_take) && (w_held || w_take) && !bvalid;

  assign rd_addr = araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready  <= 1'b0;
      wready   <= 1'b0;
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      wr_addr  <= 8'h00;
      wr_data  <= 32'h0000_0000;
      wr_strb  <= 4'h0;
      wr_pulse <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= lie_pkg::LIE_RESP_OKAY;
    end else begin
      awready  <= !aw_held && !aw_take && !bvalid && !next_fire;
      wready   <= !w_held && !w_take && !bvalid && !next_fire;
      if (aw_take) begin
        wr_addr <= awaddr;
      end
      if (w_take) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      aw_held  <= next_fire ? 1'b0 : (aw_held || aw_take);
      w_held   <= next_fire ? 1'b0 : (w_held || w_take);
      wr_pulse <= next_fire;
      if (wr_pulse) begin
        bvalid <= 1'b1;
        bresp  <= wr_ok ? lie_pkg::LIE_RESP_OKAY : lie_pkg::LIE_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= lie_pkg::LIE_RESP_OKAY;
    end else begin
      arready <= !rvalid && !ar_take;
      if (ar_take) begin
        rvalid <= 1'b1;
        rdata  <= rd_data;
        rresp  <= rd_ok ? lie_pkg::LIE_RESP_OKAY : lie_pkg::LIE_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

//--- rtl/lie_cycle_monitor.sv
// Cycle timing watcher: overrun, lost and mismatch detection
`timescale 1ns/1ps
module lie_cycle_monitor (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire lie_pkg::lie_cycle_s cyc,
  input  wire logic             new_cycle,
  input  wire logic [6:0]       local_seconds,
  input  wire logic [12:0]      local_count,
  input  wire logic             master_en,
  output logic                  overrun,
  output logic                  lost,
  output logic                  mismatch
);
  typedef enum logic [1:0] {LIE_IDLE, LIE_WAIT_START, LIE_SEEN_START} lie_cyc_e;
  lie_cyc_e   state;
  lie_cyc_e   next_state;
  logic [15:0] run_cnt;
  logic        running;
  logic        first_gap;

  wire start_seen = cyc.cycle_start_sent || cyc.cycle_start_rcvd;
  // Early prediction: gap with no start, or arbitration reset before start
  wire predict = (state == LIE_WAIT_START) && !start_seen
                 && ((cyc.subaction_gap && first_gap) || cyc.arb_reset_gap);
  wire missed  = (state == LIE_WAIT_START) && new_cycle && !start_seen;
  wire limit_hit = running
                   && (run_cnt >= 16'(lie_pkg::LIE_CYCLE_LIMIT_CYC));

  always_comb begin
    next_state = state;
    case (state)
      LIE_IDLE:       if (new_cycle) next_state = LIE_WAIT_START;
      LIE_WAIT_START: begin
        if (start_seen) next_state = LIE_SEEN_START;
        else if (predict) next_state = LIE_IDLE;
      end
      LIE_SEEN_START: if (new_cycle) next_state = LIE_WAIT_START;
      default:        next_state = LIE_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= LIE_IDLE;
      first_gap <= 1'b0;
      run_cnt   <= 16'h0000;
      running   <= 1'b0;
      overrun   <= 1'b0;
      lost      <= 1'b0;
      mismatch  <= 1'b0;
    end else begin
      state     <= next_state;
      first_gap <= new_cycle ? 1'b1 : (cyc.subaction_gap ? 1'b0 : first_gap);
      lost      <= missed || predict;
      mismatch  <= cyc.cycle_start_rcvd && ((cyc.rx_seconds != local_seconds)
                   || (cyc.rx_count != local_count));
      if (cyc.cycle_start_sent && master_en) begin
        running <= 1'b1;
        run_cnt <= 16'h0000;
      end else if (cyc.subaction_gap || limit_hit) begin
        running <= 1'b0;
      end else if (running) begin
        run_cnt <= run_cnt + 16'h0001;
      end
      overrun   <= limit_hit && master_en && !cyc.subaction_gap;
    end
  end
endmodule

//--- rtl/lie_event_reg.sv
// Link interrupt event register with set and clear addresses over AXI4-Lite
// What this block does
// - Source rising edge or set-write sets bit
// - Only clear-address one-writes clear bits
// - Reads return events ANDed with mask
// - Bits 31, 30, 28 read zero
// - Software event bit set and cleared by writes
// - Tardy event on FIFO, busy, tardy ack
// - PHY byte sets event, readable bits 23-16
// - Cycle master overrun past 125 us sets event
// - Overrun clears cycle master enable
// - Fatal error event on subunit stop
// - Fatal blocks causing contexts' normal events
// - Mismatched received cycle start sets event
// - No cycle start between new cycles: lost
// - Lost cycle may be predicted early
// - Seconds counter bit six change sets event
// - Cycle count LSB toggle sets new cycle
// - PHY status transfer interrupt sets event
// - Failed access sets flag before next access
// - Listed bits reset to zero
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module lie_event_reg (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [7:0]          araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire lie_pkg::lie_src_s   src,
  input  wire lie_pkg::lie_cycle_s cyc,
  input  wire logic [6:0]          cycle_seconds_field,
  input  wire logic [12:0]         cycle_count_field,
  output logic                     irq,
  output logic                     cycle_master_enable
);
  logic        wr_pulse;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [7:0]  rd_addr;
  logic [31:0] events;
  logic [31:0] mask;
  logic        tardy_ack_event_enable;
  logic [7:0]  phy_reg_data;
  logic [31:0] src_prev;
  logic        sec_prev;
  logic        cnt_prev;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_mux;
  logic        new_cycle_edge;
  logic        overrun;
  logic        lost;
  logic        mismatch;

  lie_axil_slave i_lie_axil_slave (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .awaddr   (awaddr),
    .awvalid  (awvalid),
    .awready  (awready),
    .wdata    (wdata),
    .wstrb    (wstrb),
    .wvalid   (wvalid),
    .wready   (wready),
    .bresp    (bresp),
    .bvalid   (bvalid),
    .bready   (bready),
    .araddr   (araddr),
    .arvalid  (arvalid),
    .arready  (arready),
    .rdata    (rdata),
    .rresp    (rresp),
    .rvalid   (rvalid),
    .rready   (rready),
    .wr_pulse (wr_pulse),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .wr_strb  (wr_strb),
    .wr_ok    (wr_hit),
    .rd_addr  (rd_addr),
    .rd_data  (rd_mux),
    .rd_ok    (rd_hit)
  );

  lie_cycle_monitor i_lie_cycle_monitor (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .cyc           (cyc),
    .new_cycle     (new_cycle_edge),
    .local_seconds (cycle_seconds_field),
    .local_count   (cycle_count_field),
    .master_en     (cycle_master_enable),
    .overrun       (overrun),
    .lost          (lost),
    .mismatch      (mismatch)
  );

  // Byte enables widened to a bit mask
  wire [31:0] strb_bits = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                           {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [31:0] wr_bits   = wr_data & strb_bits & lie_pkg::LIE_EVENT_MASK;

  wire sel_set   = wr_pulse && (wr_addr == lie_pkg::LIE_OFF_EVENT_SET);
  wire sel_clr   = wr_pulse && (wr_addr == lie_pkg::LIE_OFF_EVENT_CLEAR);
  wire sel_mask  = wr_pulse && (wr_addr == lie_pkg::LIE_OFF_MASK);
  wire sel_ctl   = wr_pulse && (wr_addr == lie_pkg::LIE_OFF_CONTROL);
  assign wr_hit  = (wr_addr == lie_pkg::LIE_OFF_EVENT_SET)
                   || (wr_addr == lie_pkg::LIE_OFF_EVENT_CLEAR)
                   || (wr_addr == lie_pkg::LIE_OFF_MASK)
                   || (wr_addr == lie_pkg::LIE_OFF_CONTROL);

  wire [31:0] masked = events & mask & lie_pkg::LIE_EVENT_MASK;
  wire [31:0] ctl_word = {30'h0000_0000, cycle_master_enable, tardy_ack_event_enable};
  wire [31:0] phy_word = {8'h00, phy_reg_data, 16'h0000};
  assign rd_hit = (rd_addr == lie_pkg::LIE_OFF_EVENT_SET)
                  || (rd_addr == lie_pkg::LIE_OFF_EVENT_CLEAR)
                  || (rd_addr == lie_pkg::LIE_OFF_MASK)
                  || (rd_addr == lie_pkg::LIE_OFF_CONTROL)
                  || (rd_addr == lie_pkg::LIE_OFF_PHY_DATA);
  assign rd_mux = ((rd_addr == lie_pkg::LIE_OFF_EVENT_SET)
                   || (rd_addr == lie_pkg::LIE_OFF_EVENT_CLEAR)) ? masked
                : (rd_addr == lie_pkg::LIE_OFF_MASK) ? (mask & lie_pkg::LIE_EVENT_MASK)
                : (rd_addr == lie_pkg::LIE_OFF_CONTROL) ? ctl_word
                : (rd_addr == lie_pkg::LIE_OFF_PHY_DATA) ? phy_word
                : 32'h0000_0000;

  // Level sources; hardware sets on their rising edge
  wire tardy_cond = tardy_ack_event_enable && (src.rx_fifo_host_data
                    || src.phys_resp_busy || src.tardy_ack_sent);
  wire access_fail = src.access_attempt && src.link_clock_missing;
  assign new_cycle_edge = cycle_count_field[0] ^ cnt_prev;

  logic [31:0] src_now;
  always_comb begin
    src_now = 32'h0000_0000;
    src_now[lie_pkg::LIE_BIT_TARDY]     = tardy_cond;
    src_now[lie_pkg::LIE_BIT_PHY_REG]   = src.phy_reg_valid;
    src_now[lie_pkg::LIE_BIT_FATAL]     = src.fatal_error;
    src_now[lie_pkg::LIE_BIT_PHY_INT]   = src.phy_status_int;
  end

  // Single-cycle detector outputs are already one pulse per event
  logic [31:0] hw_pulse;
  always_comb begin
    hw_pulse = src_now & ~src_prev;
    hw_pulse[lie_pkg::LIE_BIT_OVERRUN]   = overrun;
    hw_pulse[lie_pkg::LIE_BIT_MISMATCH]  = mismatch;
    hw_pulse[lie_pkg::LIE_BIT_LOST]      = lost;
    hw_pulse[lie_pkg::LIE_BIT_SIXTYFOUR] = cycle_seconds_field[lie_pkg::LIE_SECONDS_HI]
                                           ^ sec_prev;
    hw_pulse[lie_pkg::LIE_BIT_NEW_CYCLE] = new_cycle_edge;
    hw_pulse[lie_pkg::LIE_BIT_ACCESS]    = access_fail;
  end

  // While fatal is pending, the cycle-context events are held off
  localparam logic [31:0] CTX_BITS = 32'h00F0_0000;
  wire [31:0] hw_gated = events[lie_pkg::LIE_BIT_FATAL]
                         ? (hw_pulse & ~CTX_BITS) : hw_pulse;

  wire [31:0] clr_bits = sel_clr ? wr_bits : 32'h0000_0000;
  wire [31:0] set_bits = (sel_set ? wr_bits : 32'h0000_0000) | hw_gated;
  // Set wins over a clear in the same cycle so no event is lost
  wire [31:0] next_events = ((events & ~clr_bits) | set_bits) & lie_pkg::LIE_EVENT_MASK;
  // Request follows a mask write in the same cycle, not one late
  wire [31:0] next_mask = sel_mask ? ((mask & ~strb_bits) | (wr_data & strb_bits)) : mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      events   <= lie_pkg::LIE_RESET_EVENTS;
      src_prev <= 32'h0000_0000;
      irq      <= 1'b0;
    end else begin
      events   <= next_events;
      src_prev <= src_now;
      irq      <= |(next_events & next_mask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask                   <= lie_pkg::LIE_RESET_MASK;
      tardy_ack_event_enable <= lie_pkg::LIE_RESET_CONTROL[lie_pkg::CTL_BIT_TARDY_EN];
      cycle_master_enable    <= lie_pkg::LIE_RESET_CONTROL[lie_pkg::CTL_BIT_CYC_MSTR];
      phy_reg_data           <= 8'h00;
      sec_prev               <= 1'b0;
      cnt_prev               <= 1'b0;
    end else begin
      sec_prev <= cycle_seconds_field[lie_pkg::LIE_SECONDS_HI];
      cnt_prev <= cycle_count_field[0];
      mask     <= next_mask;
      if (sel_ctl && wr_strb[0]) begin
        tardy_ack_event_enable <= wr_data[lie_pkg::CTL_BIT_TARDY_EN];
      end
      if (overrun) begin
        cycle_master_enable <= 1'b0;
      end else if (sel_ctl && wr_strb[0]) begin
        cycle_master_enable <= wr_data[lie_pkg::CTL_BIT_CYC_MSTR];
      end
      if (src.phy_reg_valid) begin
        phy_reg_data <= src.phy_reg_byte;
      end
    end
  end

  property p_clear_only_by_write;
    @(posedge aclk) disable iff (!aresetn)
      ($past(events[lie_pkg::LIE_BIT_SOFT]) && !events[lie_pkg::LIE_BIT_SOFT])
        |-> $past(sel_clr && wr_bits[lie_pkg::LIE_BIT_SOFT]);
  endproperty
  a_clear_only_by_write: assert property (p_clear_only_by_write)
    else $error("event bit cleared without clear write");

  property p_set_write;
    @(posedge aclk) disable iff (!aresetn)
      (sel_set && wr_bits[lie_pkg::LIE_BIT_SOFT]) |=> events[lie_pkg::LIE_BIT_SOFT];
  endproperty
  a_set_write: assert property (p_set_write)
    else $error("set write did not set software event");

  property p_reserved_zero;
    @(posedge aclk) disable iff (!aresetn)
      rvalid |-> (rdata[31:30] == 2'h0) && (rdata[28] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved event bit reads nonzero");

  property p_phy_edge;
    @(posedge aclk) disable iff (!aresetn)
      $rose(src.phy_status_int) |=> events[lie_pkg::LIE_BIT_PHY_INT];
  endproperty
  a_phy_edge: assert property (p_phy_edge)
    else $error("phy interrupt edge not latched");

  property p_overrun_master;
    @(posedge aclk) disable iff (!aresetn)
      overrun |=> !cycle_master_enable && events[lie_pkg::LIE_BIT_OVERRUN];
  endproperty
  a_overrun_master: assert property (p_overrun_master)
    else $error("overrun did not drop cycle master");

  property p_irq_level;
    @(posedge aclk) disable iff (!aresetn)
      ##1 (irq == |(events & mask));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt request disagrees with masked events");

  property p_new_cycle;
    @(posedge aclk) disable iff (!aresetn)
      ($changed(cycle_count_field[0]) && !events[lie_pkg::LIE_BIT_FATAL])
        |=> events[lie_pkg::LIE_BIT_NEW_CYCLE];
  endproperty
  a_new_cycle: assert property (p_new_cycle)
    else $error("count toggle did not set new cycle");

  property p_access_fail;
    @(posedge aclk) disable iff (!aresetn)
      (src.access_attempt && src.link_clock_missing) |=> events[lie_pkg::LIE_BIT_ACCESS];
  endproperty
  a_access_fail: assert property (p_access_fail)
    else $error("failed access not flagged");
endmodule

//--- verification/tb_lie_event_reg.sv
// Directed testbench for the link interrupt event register
`timescale 1ns/1ps
module tb_lie_event_reg;
  localparam logic [7:0]  SET = lie_pkg::LIE_OFF_EVENT_SET;
  localparam logic [7:0]  CLR = lie_pkg::LIE_OFF_EVENT_CLEAR;
  localparam logic [7:0]  MSK = lie_pkg::LIE_OFF_MASK;
  localparam logic [7:0]  CTL = lie_pkg::LIE_OFF_CONTROL;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] EVM = lie_pkg::LIE_EVENT_MASK;
  localparam logic [1:0]  OK  = lie_pkg::LIE_RESP_OKAY;
  localparam logic [1:0]  ERR = lie_pkg::LIE_RESP_SLVERR;
  logic                aclk;
  logic                aresetn;
  logic                awvalid;
  logic                wvalid;
  logic                bready;
  logic                arvalid;
  logic                rready;
  logic                awready;
  logic                wready;
  logic                bvalid;
  logic                arready;
  logic                rvalid;
  logic                irq;
  logic                cycle_master_enable;
  logic [7:0]          awaddr;
  logic [7:0]          araddr;
  logic [31:0]         wdata;
  logic [31:0]         rdata;
  logic [3:0]          wstrb;
  logic [1:0]          bresp;
  logic [1:0]          rresp;
  lie_pkg::lie_src_s   src;
  lie_pkg::lie_cycle_s cyc;
  logic [6:0]          sec;
  logic [12:0]         cnt;
  int                  fail_count;
  int                  total_checks;

  lie_event_reg i_lie_event_reg (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .src(src), .cyc(cyc), .cycle_seconds_field(sec), .cycle_count_field(cnt),
    .irq(irq), .cycle_master_enable(cycle_master_enable)
  );

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  function automatic logic [31:0] b(input int n);
    return 32'h0000_0001 << n;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic hang(input int n);
    if (n >= 200) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, 32'h0, 32'h1);
      close_out();
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // Address and data offered together; each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic ad;
    logic wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ad && wd) && n < 200);
    hang(n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid !== 1'b1 && n < 200);
    hang(n);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 200);
    hang(n);
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 200);
    hang(n);
    rready <= 1'b0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic rcvd(input logic [6:0] s, input logic [12:0] c);
    cyc.rx_seconds <= s;
    cyc.rx_count <= c;
    cyc.cycle_start_rcvd <= 1'b1;
    tick(1);
    cyc.cycle_start_rcvd <= 1'b0;
    tick(2);
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    src = '0;
    cyc = '0;
    sec = 7'h00;
    cnt = 13'h0000;
    fail_count = 0;
    total_checks = 0;
    tick(6);
    aresetn <= 1'b1;
    wr(MSK, ALL, OK);
    rd(SET, 32'h0, OK);
    rd(CTL, 32'h0, OK);
    chk({31'h0, irq}, 32'h0);
    wr(SET, ALL, OK);
    rd(SET, EVM, OK);
    rd(CLR, EVM, OK);
    chk({31'h0, irq}, 32'h1);
    wr(SET, 32'h0, OK);
    wr(CLR, 32'h0, OK);
    rd(SET, EVM, OK);
    wr(CLR, b(29), OK);
    rd(SET, EVM & ~b(29), OK);
    wr(MSK, b(26), OK);
    rd(CLR, b(26), OK);
    wr(MSK, 32'h0, OK);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    wr(MSK, ALL, OK);
    wr(CLR, ALL, OK);
    rd(SET, 32'h0, OK);
    // Top byte lane only
    wstrb <= 4'h8;
    wr(SET, ALL, OK);
    wstrb <= 4'hF;
    rd(SET, EVM & 32'hFF00_0000, OK);
    wr(CLR, ALL, OK);
    // Each tardy cause alone, first with the enable off
    for (int e = 0; e < 2; e++) begin
      wr(CTL, e, OK);
      for (int i = 0; i < 3; i++) begin
        {src.rx_fifo_host_data, src.phys_resp_busy, src.tardy_ack_sent} <= 3'h4 >> i;
        tick(3);
        rd(SET, (e == 1) ? b(27) : 32'h0, OK);
        {src.rx_fifo_host_data, src.phys_resp_busy, src.tardy_ack_sent} <= 3'h0;
        tick(2);
        wr(CLR, ALL, OK);
      end
    end
    wr(CTL, 32'h0, OK);
    src.phy_reg_byte <= 8'hA5;
    src.phy_reg_valid <= 1'b1;
    tick(1);
    src.phy_reg_valid <= 1'b0;
    tick(2);
    rd(SET, b(26), OK);
    rd(lie_pkg::LIE_OFF_PHY_DATA, 32'h00A5_0000, OK);
    wr(CLR, ALL, OK);
    // Held level must not set the bit again after clearing
    src.phy_status_int <= 1'b1;
    tick(3);
    rd(SET, b(19), OK);
    wr(CLR, b(19), OK);
    rd(SET, 32'h0, OK);
    src.phy_status_int <= 1'b0;
    src.link_clock_missing <= 1'b1;
    src.access_attempt <= 1'b1;
    tick(1);
    src.access_attempt <= 1'b0;
    src.link_clock_missing <= 1'b0;
    tick(2);
    rd(SET, b(18), OK);
    wr(CLR, ALL, OK);
    sec <= 7'h40;
    tick(3);
    rd(SET, b(21), OK);
    wr(CLR, ALL, OK);
    rcvd(7'h40, 13'h0000);
    rd(SET, 32'h0, OK);
    rcvd(7'h40, 13'h0002);
    rd(SET, b(23), OK);
    wr(CLR, ALL, OK);
    cnt <= 13'h0001;
    tick(3);
    rd(SET, b(20), OK);
    wr(CLR, ALL, OK);
    cnt <= 13'h0000;
    tick(3);
    rd(SET, b(20) | b(22), OK);
    wr(CLR, ALL, OK);
    src.fatal_error <= 1'b1;
    tick(3);
    rd(SET, b(24), OK);
    cnt <= 13'h0001;
    tick(3);
    rd(SET, b(24), OK);
    wr(CLR, b(24), OK);
    src.fatal_error <= 1'b0;
    cnt <= 13'h0000;
    tick(3);
    rd(SET, b(20) | b(22), OK);
    // First gap after a new cycle with no start predicts a loss
    wr(CLR, ALL, OK);
    cyc.subaction_gap <= 1'b1;
    tick(1);
    cyc.subaction_gap <= 1'b0;
    tick(2);
    rd(SET, b(22), OK);
    wr(CLR, ALL, OK);
    cnt <= 13'h0001;
    tick(3);
    cyc.arb_reset_gap <= 1'b1;
    tick(1);
    cyc.arb_reset_gap <= 1'b0;
    tick(2);
    rd(SET, b(20) | b(22), OK);
    // Only the overrun bit is visible here; lost prediction may fire
    wr(CLR, ALL, OK);
    wr(MSK, b(25), OK);
    wr(CTL, 32'h2, OK);
    tick(2);
    chk({31'h0, cycle_master_enable}, 32'h1);
    cyc.cycle_start_sent <= 1'b1;
    tick(1);
    cyc.cycle_start_sent <= 1'b0;
    tick(100);
    cyc.subaction_gap <= 1'b1;
    tick(1);
    cyc.subaction_gap <= 1'b0;
    tick(lie_pkg::LIE_CYCLE_LIMIT_CYC + 10);
    rd(SET, 32'h0, OK);
    cyc.cycle_start_sent <= 1'b1;
    tick(1);
    cyc.cycle_start_sent <= 1'b0;
    tick(lie_pkg::LIE_CYCLE_LIMIT_CYC + 10);
    rd(SET, b(25), OK);
    chk({31'h0, cycle_master_enable}, 32'h0);
    rd(CTL, 32'h0, OK);
    rd(8'h00, 32'h0, ERR);
    wr(8'h04, ALL, ERR);
    close_out();
  end
endmodule
